// [design/gpatc_params.svh]
// constants for the pin configuration and adaptive start-temperature block
`ifndef GPATC_PARAMS_SVH
`define GPATC_PARAMS_SVH

// -----------------------------------------------------------------------
// register byte addresses (printed offsets are indices, address = 4*index)
// -----------------------------------------------------------------------
`define GPATC_IDX_PIN_CFG_LOWER    8'h09
`define GPATC_IDX_PIN_CFG_UPPER    8'h0a
`define GPATC_IDX_ADAPT_CTRL       8'h0b
`define GPATC_IDX_PIN_ENABLE       8'h03
`define GPATC_IDX_OP_POINT_A       8'h10
`define GPATC_IDX_OP_POINT_B       8'h11
`define GPATC_IDX_SW_RESET         8'h12
`define GPATC_IDX_PIN_STATE        8'h13

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define GPATC_RST_CFG              8'h00
`define GPATC_RST_OP_POINT         8'hff

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define GPATC_BIT_ADAPT_A          0
`define GPATC_BIT_ADAPT_B          1
`define GPATC_BIT_CAP_AA           2
`define GPATC_BIT_CAP_AB           3
`define GPATC_BIT_CAP_BA           4
`define GPATC_BIT_CAP_BB           5
`define GPATC_BIT_PIN_EN           0
`define GPATC_BIT_SW_RESET         0

`endif

// [design/gpatc_pkg.sv]
// types shared by the pin configuration block
package gpatc_pkg;
  typedef logic [7:0] gpatc_byte_t;
  typedef logic [7:0] gpatc_pins_t;
endpackage : gpatc_pkg

// [design/gpatc_pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ns
module gpatc_pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // -----------------------------------------------------------------------
  // sampling chain
  // -----------------------------------------------------------------------
  // s1 is read only by s2, so metastability never reaches the filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule : gpatc_pin_sync

// [design/gpatc_top.sv]
// pin configuration and adaptive start-temperature control, APB slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "gpatc_params.svh"

// Summary of operation
// - even bits of the lower pin register set pins 1-4 polarity, 1 high.
// - odd bits of the lower pin register set pins 1-4 direction, 1 out.
// - even bits of the upper pin register set pins 5-8 polarity.
// - odd bits of the upper pin register set pins 5-8 direction.
// - all three configuration registers clear on reset and soft reset.
// - adaptive control bit 0 enables adaptive start temp on channel a.
// - adaptive control bit 1 enables adaptive start temp on channel b.
// - bit 2 lets alarm pin a copy channel a temp to its operating point.
// - bit 3 lets alarm pin a copy channel b temp to its operating point.
// - bit 4 lets alarm pin b copy channel a temp to its operating point.
// - bit 5 lets alarm pin b copy channel b temp to its operating point.
// - a copy happens only when the temperature is below the held value.
// - with a capture bit clear the alarm is ignored for that channel.
// - adaptive control bits 7 and 6 are reserved with no function.
// - pins operate only while the pin enable bit 0 is set.
module gpatc_top (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [7:0]    pin_in,
  output logic [7:0]         pin_out,
  output logic [7:0]         pin_oe,
  input  wire logic [7:0]    logic_out,
  output logic [7:0]         logic_in,
  input  wire logic          thermal_alarm_pin_a_n,
  input  wire logic          thermal_alarm_pin_b_n,
  input  wire gpatc_pkg::gpatc_byte_t temp_chan_a,
  input  wire gpatc_pkg::gpatc_byte_t temp_chan_b,
  output logic [7:0]         op_point_a,
  output logic [7:0]         op_point_b,
  output logic               adaptive_en_a,
  output logic               adaptive_en_b
);
  import gpatc_pkg::*;

  gpatc_byte_t pin_config_lower_reg;
  gpatc_byte_t pin_config_upper_reg;
  gpatc_byte_t adaptive_start_temp_ctrl_reg;
  logic        pin_enable_reg;
  logic        soft_reset_reg;
  gpatc_pins_t polarity;
  gpatc_pins_t direction;
  gpatc_pins_t pin_sync;
  logic        alarm_a_sync;
  logic        alarm_b_sync;
  logic        alarm_a_prev_reg;
  logic        alarm_b_prev_reg;
  logic        alarm_a_rise;
  logic        alarm_b_rise;
  logic        capture_a;
  logic        capture_b;
  logic        wr_en;
  logic        rd_en;
  logic [9:0]  word_addr;
  logic        addr_hit;
  logic [31:0] rdata_next;
  logic [7:0]  op_point_a_next;
  logic [7:0]  op_point_b_next;

  // -----------------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------------
  // single-cycle access phase: pready is a flop set during setup
  assign word_addr = paddr[11:2];
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    addr_hit   = 1'b1;
    case (word_addr)
      {2'b00, `GPATC_IDX_PIN_CFG_LOWER}: begin
        rdata_next[7:0] = pin_config_lower_reg;
      end
      {2'b00, `GPATC_IDX_PIN_CFG_UPPER}: begin
        rdata_next[7:0] = pin_config_upper_reg;
      end
      {2'b00, `GPATC_IDX_ADAPT_CTRL}: begin
        rdata_next[7:0] = adaptive_start_temp_ctrl_reg;
      end
      {2'b00, `GPATC_IDX_PIN_ENABLE}: begin
        rdata_next[0] = pin_enable_reg;
      end
      {2'b00, `GPATC_IDX_OP_POINT_A}: begin
        rdata_next[7:0] = op_point_a;
      end
      {2'b00, `GPATC_IDX_OP_POINT_B}: begin
        rdata_next[7:0] = op_point_b;
      end
      {2'b00, `GPATC_IDX_SW_RESET}: begin
        rdata_next = 32'h0000_0000;
      end
      {2'b00, `GPATC_IDX_PIN_STATE}: begin
        rdata_next[7:0] = logic_in;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= rd_en ? rdata_next : 32'h0000_0000;
      pslverr <= !addr_hit;
    end else begin
      // error flag stands for the access cycle only
      pslverr <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------------
  // soft reset is a self-clearing pulse; it wipes config a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_en && addr_hit &&
        (word_addr == {2'b00, `GPATC_IDX_SW_RESET}) &&
        pwdata[`GPATC_BIT_SW_RESET];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_config_lower_reg         <= `GPATC_RST_CFG;
      pin_config_upper_reg         <= `GPATC_RST_CFG;
      adaptive_start_temp_ctrl_reg <= `GPATC_RST_CFG;
      pin_enable_reg               <= 1'b0;
    end else if (soft_reset_reg) begin
      pin_config_lower_reg         <= `GPATC_RST_CFG;
      pin_config_upper_reg         <= `GPATC_RST_CFG;
      adaptive_start_temp_ctrl_reg <= `GPATC_RST_CFG;
      pin_enable_reg               <= 1'b0;
    end else if (wr_en) begin
      case (word_addr)
        {2'b00, `GPATC_IDX_PIN_CFG_LOWER}: begin
          pin_config_lower_reg <= pwdata[7:0];
        end
        {2'b00, `GPATC_IDX_PIN_CFG_UPPER}: begin
          pin_config_upper_reg <= pwdata[7:0];
        end
        // reserved bits 7:6 store but drive nothing
        {2'b00, `GPATC_IDX_ADAPT_CTRL}: begin
          adaptive_start_temp_ctrl_reg <= pwdata[7:0];
        end
        {2'b00, `GPATC_IDX_PIN_ENABLE}: begin
          pin_enable_reg <= pwdata[`GPATC_BIT_PIN_EN];
        end
        // unmapped words drop the write; pslverr already flagged them
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // general pins
  // -----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_split
      assign polarity[gi]    = pin_config_lower_reg[2*gi];
      assign direction[gi]   = pin_config_lower_reg[2*gi+1];
      assign polarity[gi+4]  = pin_config_upper_reg[2*gi];
      assign direction[gi+4] = pin_config_upper_reg[2*gi+1];
    end
    for (gi = 0; gi < 8; gi++) begin : g_pin
      gpatc_pin_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (pin_in[gi]),
        .level_out (pin_sync[gi])
      );
      // disabled pins float and read as deasserted
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_oe[gi]   <= 1'b0;
          pin_out[gi]  <= 1'b0;
          logic_in[gi] <= 1'b0;
        end else begin
          pin_oe[gi]   <= pin_enable_reg && direction[gi];
          // active low unless polarity is 1
          pin_out[gi]  <= !(logic_out[gi] ^ polarity[gi]);
          logic_in[gi] <= pin_enable_reg && !direction[gi] &&
                          !(pin_sync[gi] ^ polarity[gi]);
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------------
  // adaptive start temperature and alarm capture
  // -----------------------------------------------------------------------
  gpatc_pin_sync u_alarm_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (!thermal_alarm_pin_a_n),
    .level_out (alarm_a_sync)
  );
  gpatc_pin_sync u_alarm_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (!thermal_alarm_pin_b_n),
    .level_out (alarm_b_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_a_prev_reg <= 1'b0;
      alarm_b_prev_reg <= 1'b0;
    end else begin
      alarm_a_prev_reg <= alarm_a_sync;
      alarm_b_prev_reg <= alarm_b_sync;
    end
  end

  // enables pass through a flop so every output is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adaptive_en_a <= 1'b0;
      adaptive_en_b <= 1'b0;
    end else begin
      adaptive_en_a <=
        adaptive_start_temp_ctrl_reg[`GPATC_BIT_ADAPT_A];
      adaptive_en_b <=
        adaptive_start_temp_ctrl_reg[`GPATC_BIT_ADAPT_B];
    end
  end

  // one copy per assertion edge, not per cycle held
  assign alarm_a_rise = alarm_a_sync && !alarm_a_prev_reg;
  assign alarm_b_rise = alarm_b_sync && !alarm_b_prev_reg;

  // a cleared capture bit masks its alarm for that channel
  always_comb begin
    capture_a = 1'b0;
    capture_b = 1'b0;
    if (alarm_a_rise && adaptive_start_temp_ctrl_reg[`GPATC_BIT_CAP_AA]) begin
      capture_a = 1'b1;
    end
    if (alarm_a_rise && adaptive_start_temp_ctrl_reg[`GPATC_BIT_CAP_AB]) begin
      capture_b = 1'b1;
    end
    if (alarm_b_rise && adaptive_start_temp_ctrl_reg[`GPATC_BIT_CAP_BA]) begin
      capture_a = 1'b1;
    end
    if (alarm_b_rise && adaptive_start_temp_ctrl_reg[`GPATC_BIT_CAP_BB]) begin
      capture_b = 1'b1;
    end
  end

  // software write wins over a capture in the same cycle
  always_comb begin
    op_point_a_next = op_point_a;
    op_point_b_next = op_point_b;
    if (wr_en && word_addr == {2'b00, `GPATC_IDX_OP_POINT_A}) begin
      op_point_a_next = pwdata[7:0];
    end else if (capture_a && temp_chan_a < op_point_a) begin
      op_point_a_next = temp_chan_a;
    end
    if (wr_en && word_addr == {2'b00, `GPATC_IDX_OP_POINT_B}) begin
      op_point_b_next = pwdata[7:0];
    end else if (capture_b && temp_chan_b < op_point_b) begin
      op_point_b_next = temp_chan_b;
    end
  end

  // the compare uses the held value, so a capture can only lower it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_point_a <= `GPATC_RST_OP_POINT;
      op_point_b <= `GPATC_RST_OP_POINT;
    end else begin
      op_point_a <= op_point_a_next;
      op_point_b <= op_point_b_next;
    end
  end
endmodule : gpatc_top

// [verif/gpatc_props.sv]
// assertion checker on the pin config block ports
`timescale 1ns/1ns
module gpatc_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] logic_in,
  input wire logic       thermal_alarm_pin_a_n,
  input wire logic       thermal_alarm_pin_b_n,
  input wire logic [7:0] op_point_a,
  input wire logic [7:0] op_point_b,
  input wire logic       adaptive_en_a,
  input wire logic       adaptive_en_b
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // helpers
  // ----
  logic       wr_acc;
  logic [3:0] since_alarm;
  assign wr_acc = psel && penable && pwrite && pready;
  // saturating age of the last alarm, a capture must follow one closely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_alarm <= 4'hf;
    else if (!thermal_alarm_pin_a_n || !thermal_alarm_pin_b_n)
      since_alarm <= 4'h0;
    else if (since_alarm != 4'hf)
      since_alarm <= since_alarm + 4'h1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    pready ##1 !pready;
  endsequence
  // ----
  // properties
  // ----
  property p_ready;
    s_setup |=> s_access;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_rst;
    $rose(presetn) |-> pin_oe == 8'h00 && !adaptive_en_a && !adaptive_en_b;
  endproperty
  // a soft reset wipes the enables one cycle later than a plain write
  property p_en_a;
    $changed(adaptive_en_a) |->
      $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3);
  endproperty
  property p_en_b;
    $changed(adaptive_en_b) |->
      $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3);
  endproperty
  property p_op_a;
    $changed(op_point_a) && !$past(wr_acc) |-> op_point_a < $past(op_point_a);
  endproperty
  property p_op_b;
    $changed(op_point_b) && !$past(wr_acc) |-> op_point_b < $past(op_point_b);
  endproperty
  property p_cause;
    ($changed(op_point_a) || $changed(op_point_b)) && !$past(wr_acc)
      |-> since_alarm < 4'hc;
  endproperty
  property p_dir;
    $stable(pin_oe) [*6] |-> (logic_in & pin_oe) == 8'h00;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_rst: assert property (p_rst) else $error("bad reset value");
  a_en_a: assert property (p_en_a) else $error("en a moved");
  a_en_b: assert property (p_en_b) else $error("en b moved");
  a_op_a: assert property (p_op_a) else $error("op a rose");
  a_op_b: assert property (p_op_b) else $error("op b rose");
  a_cause: assert property (p_cause) else $error("op w/o alarm");
  a_dir: assert property (p_dir) else $error("output sensed");
endmodule : gpatc_props

// [verif/gpatc_top_tb.sv]
// self-checking bench for the pin config block
`timescale 1ns/1ns
module gpatc_top_tb;
  import gpatc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, en;
  logic        thermal_alarm_pin_a_n, thermal_alarm_pin_b_n;
  logic        adaptive_en_a, adaptive_en_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pin_in, pin_out, pin_oe, logic_out, logic_in, lo, up, pol;
  logic [7:0]  dir, m, c, op_point_a, op_point_b;
  gpatc_byte_t temp_chan_a, temp_chan_b;
  logic [32:0] exp_q[$];
  int          n_mismatch, num_checks;
  gpatc_top u_dut (.*);
  always #2 pclk = ~pclk;
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [32:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] ix, input logic [7:0] d, input logic er);
    exp_q.push_back({er, 24'h0, d});
    apb(1'b0, ix, 8'h00);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // read results are taken at the edge that samples pready
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk("read", exp_q.pop_front(), {pslverr, prdata});
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  // ----
  // main sequence
  // ----
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_in, logic_out, temp_chan_a, temp_chan_b} = '0;
    thermal_alarm_pin_a_n = 1'b1;
    thermal_alarm_pin_b_n = 1'b1;
    void'($urandom(62));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(10'h09, 8'h00, 1'b0);
    rd(10'h0a, 8'h00, 1'b0);
    rd(10'h0b, 8'h00, 1'b0);
    rd(10'h3f, 8'h00, 1'b1);
    for (int k = 0; k < 6; k++) begin
      en = k[0];
      lo = 8'($urandom);
      up = 8'($urandom);
      pin_in <= 8'($urandom);
      logic_out <= 8'($urandom);
      apb(1'b1, 10'h03, {7'h0, en});
      apb(1'b1, 10'h09, lo);
      apb(1'b1, 10'h0a, up);
      rd(10'h09, lo, 1'b0);
      rd(10'h0a, up, 1'b0);
      for (int i = 0; i < 4; i++) begin
        {dir[i], pol[i]} = lo[2*i +: 2];
        {dir[i+4], pol[i+4]} = up[2*i +: 2];
      end
      m = dir & {8{en}};
      c = (pin_in ^ ~pol) & ~dir & {8{en}};
      rd(10'h03, {7'h0, en}, 1'b0);
      rd(10'h13, c, 1'b0);
      repeat (8) @(posedge pclk);
      chk("oe", 33'(m), 33'(pin_oe));
      chk("out", 33'((logic_out ^ ~pol) & m), 33'(pin_out & m));
      chk("in", 33'(c), 33'(logic_in));
    end
    for (int k = 0; k < 4; k++) begin
      c = k[1] ? {k[0], k[0], 6'h0} : {6'h0, k[0], ~k[0]};
      apb(1'b1, 10'h0b, c);
      rd(10'h0b, c, 1'b0);
      chk("en", 33'({adaptive_en_b, adaptive_en_a}), 33'(c[1:0]));
    end
    for (int k = 0; k < 9; k++) begin
      c = k[3] ? 8'h00 : 8'h04 << k[1:0];
      temp_chan_a <= k[2] ? 8'h90 : 8'h40;
      temp_chan_b <= k[2] ? 8'ha0 : 8'h30;
      apb(1'b1, 10'h10, 8'h80);
      apb(1'b1, 10'h11, 8'h80);
      apb(1'b1, 10'h0b, c);
      thermal_alarm_pin_a_n <= !(k[3] || !k[1]);
      thermal_alarm_pin_b_n <= !(k[3] || k[1]);
      repeat (10) @(posedge pclk);
      thermal_alarm_pin_a_n <= 1'b1;
      thermal_alarm_pin_b_n <= 1'b1;
      repeat (10) @(posedge pclk);
      rd(10'h10, (k < 4 && !k[0]) ? 8'h40 : 8'h80, 1'b0);
      rd(10'h11, (k < 4 && k[0]) ? 8'h30 : 8'h80, 1'b0);
    end
    // a soft reset must clear the configuration like a power-on
    apb(1'b1, 10'h09, 8'h5a);
    apb(1'b1, 10'h0a, 8'ha5);
    apb(1'b1, 10'h0b, 8'hc3);
    apb(1'b1, 10'h12, 8'h01);
    rd(10'h09, 8'h00, 1'b0);
    rd(10'h0a, 8'h00, 1'b0);
    rd(10'h0b, 8'h00, 1'b0);
    rd(10'h03, 8'h00, 1'b0);
    @(posedge pclk);
    end_sim();
  end
endmodule : gpatc_top_tb
bind gpatc_top gpatc_props u_props (.*);
